// ===== design/ilm_host.sv
// host end: avalon-mm slave that issues link commands
`default_nettype none
module ilm_host
   import ilm_pkg::*;
(
   input  wire logic        clk,              // 20 MHz clock
   input  wire logic        rst_n,            // async reset, active low
   ilm_link_if.host         link,             // command link
   input  wire logic [3:0]  avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data
   output logic [31:0]      avs_readdata,     // read data
   output logic             avs_waitrequest   // low for one answering cycle
);
   ilm_hstate_t st_q;
   logic        req_q, wait_q, refused_q;
   logic [7:0]  cmd_q;
   logic [15:0] wdata_q;
   logic [31:0] rdata_q, rd_q;
   logic        hit, cmd_wr;

   assign hit    = (avs_read || avs_write) && wait_q;
   assign cmd_wr = avs_write && avs_address == HR_CMD;

   ////////////////////////////////////////////////////////////////////////
   // avalon answer, one idle cycle then waitrequest low; cmd waits for idle link
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
         rd_q <= '0;
      end else begin
         wait_q <= 1'b1;
         if (hit && !(cmd_wr && st_q != ILM_IDLE)) begin
            wait_q <= 1'b0;
            case (avs_address)
               HR_WDATA:  rd_q <= {16'h0000, wdata_q};
               HR_CMD:    rd_q <= {24'h000000, cmd_q};
               HR_RDATA:  rd_q <= rdata_q;
               HR_STATUS: rd_q <= {29'h0, link.irq, refused_q, st_q != ILM_IDLE};
               default:   rd_q <= '0;
            endcase
         end
      end
   end

   // link sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ILM_IDLE;
         req_q <= 1'b0;
         cmd_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         refused_q <= 1'b0;
      end else begin
         case (st_q)
            ILM_IDLE: begin
               if (!wait_q && avs_write && avs_address == HR_WDATA)
                  wdata_q <= avs_writedata[15:0];
               if (!wait_q && cmd_wr) begin
                  cmd_q <= avs_writedata[7:0];
                  req_q <= 1'b1;
                  st_q <= ILM_SEND;
               end
            end
            ILM_SEND: begin
               if (link.ack) begin
                  req_q <= 1'b0;
                  rdata_q <= link.rdata;
                  refused_q <= link.refused;
                  st_q <= ILM_WAIT;
               end
            end
            ILM_WAIT: st_q <= ILM_IDLE;
            default: st_q <= ILM_IDLE;
         endcase
      end
   end

   assign link.req        = req_q;
   assign link.cmd        = cmd_q;
   assign link.wdata      = wdata_q;
   assign avs_readdata    = rd_q;
   assign avs_waitrequest = wait_q;
endmodule
`default_nettype wire

// ===== design/ilm_link_if.sv
// command link between host controller and monitor
`default_nettype none
interface ilm_link_if;
   logic        req;       // host holds until ack
   logic [7:0]  cmd;       // command byte
   logic [15:0] wdata;     // write data
   logic        ack;       // one-cycle answer
   logic        refused;   // with ack: command not accepted
   logic [31:0] rdata;     // with ack: read data
   logic        irq;       // interrupt level
   modport dev  (input req, cmd, wdata, output ack, refused, rdata, irq);
   modport host (output req, cmd, wdata, input ack, refused, rdata, irq);
endinterface
`default_nettype wire

// ===== design/ilm_monitor.sv
// device end: flags, mask, limits, auto scheduler and pair fifo
//
// The implementer's own choice: the Avalon-MM slave port.
`default_nettype none
module ilm_monitor
   import ilm_pkg::*;
(
   input  wire logic          clk,          // 20 MHz clock
   input  wire logic          rst_n,        // async reset, active low
   ilm_link_if.dev            link,         // command link
   input  wire logic          t_done,       // temperature conversion finished
   input  wire logic [DW-1:0] t_result,     // filtered temperature, upper bits
   input  wire logic          p_done,       // pressure conversion finished
   input  wire logic [DW-1:0] p_result,     // filtered pressure, upper bits
   input  wire logic          crc_fail,     // crc check failed level
   input  wire logic          auto_on,      // automatic mode running
   input  wire logic          auto_tick,    // automatic timer cycle pulse
   input  wire logic [RW-1:0] p_ratio,      // pressure rate divider, 0 off
   input  wire logic [RW-1:0] t_ratio,      // temperature rate divider, 0 off
   input  wire logic          fifo_on,      // fifo storage enabled
   input  wire logic          fifo_wrap,    // overwrite when full
   input  wire logic [PW-1:0] fifo_thr,     // threshold, 0 disables
   output logic               conv_p,       // start pressure pulse
   output logic               conv_t,       // start temperature pulse
   output logic               cfg_wr,       // accepted config write pulse
   output logic [DW-1:0]      cfg_data,     // config write data
   output logic [PW:0]        fifo_count    // unread pairs
);
   logic [7:0]    flags_q, mask_q;
   logic [DW-1:0] lim_q [4];
   logic [DW-1:0] t_last_q, p_last_q;
   logic [2*DW-1:0] mem [FIFO_DEPTH];
   logic [PW-1:0] wp_q, rp_q;
   logic [PW:0]   cnt_q;
   logic [RW-1:0] pdiv_q, tdiv_q;
   logic          ack_q, ref_q, irq_q, conv_p_q, conv_t_q, cfg_q;
   logic [31:0]   rdata_q;
   logic [DW-1:0] cfg_data_q;
   logic          take, push, pop, cnt_full;
   logic [7:0]    set, clr;

   function automatic logic cmd7(input logic [7:0] c, input logic [6:0] code);
      return c[7:1] == code;
   endfunction

   function automatic logic cmd5(input logic [7:0] c, input logic [4:0] code);
      return c[7:3] == code;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // command acceptance, one per ack
   assign take = link.req && !ack_q;
   assign cnt_full = cnt_q == (PW+1)'(FIFO_DEPTH);
   assign push = fifo_on && auto_on && p_done && (!cnt_full || fifo_wrap);
   assign pop  = take && link.cmd[7:4] == CMD_RD_ADC && fifo_on && cnt_q != '0;

   // answer and read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         ref_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= take;
         ref_q <= 1'b0;
         if (take) begin
            rdata_q <= '0;
            if (cmd7(link.cmd, CMD_RD_MASK))
               rdata_q <= {24'h000000, mask_q};
            else if (cmd7(link.cmd, CMD_RD_FLAGS))
               rdata_q <= {24'h000000, flags_q};
            else if (cmd5(link.cmd, CMD_RD_LIMIT))
               rdata_q <= {16'h0000, lim_q[link.cmd[2:1]]};
            else if (pop)
               rdata_q <= mem[rp_q];
            else if (link.cmd[7:4] == CMD_RD_ADC)
               rdata_q <= {p_last_q, t_last_q};
            if (auto_on && (cmd5(link.cmd, CMD_WR_CFG) || link.cmd[7:4] == CMD_CONV))
               ref_q <= 1'b1;
         end
      end
   end

   // accepted config writes leave on the user side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 1'b0;
         cfg_data_q <= '0;
      end else begin
         cfg_q <= take && !auto_on && cmd5(link.cmd, CMD_WR_CFG);
         if (take && !auto_on && cmd5(link.cmd, CMD_WR_CFG))
            cfg_data_q <= link.wdata;                     // refused data never leaves
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mask register, zero from reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         mask_q <= MASK_RST;
      else if (take && cmd7(link.cmd, CMD_WR_MASK))
         mask_q <= link.wdata[7:0];
   end

   // limit registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lim_q[SEL_T_LOW]  <= LOW_RST;
         lim_q[SEL_T_HIGH] <= HIGH_RST;
         lim_q[SEL_P_LOW]  <= LOW_RST;
         lim_q[SEL_P_HIGH] <= HIGH_RST;
      end else if (take && cmd5(link.cmd, CMD_WR_LIMIT)) begin
         lim_q[link.cmd[2:1]] <= link.wdata;
      end
   end

   // latest results
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_last_q <= '0;
         p_last_q <= '0;
      end else begin
         if (t_done)
            t_last_q <= t_result;
         if (p_done)
            p_last_q <= p_result;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag events, compared once at each end of conversion
   always_comb begin
      set = '0;
      set[FL_CRC]    = crc_fail;
      set[FL_P_HIGH] = p_done && p_result > lim_q[SEL_P_HIGH];
      set[FL_P_LOW]  = p_done && p_result < lim_q[SEL_P_LOW];
      set[FL_T_HIGH] = t_done && t_result > lim_q[SEL_T_HIGH];
      set[FL_T_LOW]  = t_done && t_result < lim_q[SEL_T_LOW];
      set[FL_FULL]   = push && !pop && cnt_q == (PW+1)'(FIFO_DEPTH - 1);
      set[FL_THR]    = push && fifo_thr != '0 && !pop
                       && cnt_q + 1'b1 == {1'b0, fifo_thr};
      set[FL_DONE]   = t_done || p_done;
      clr = (take && cmd7(link.cmd, CMD_WR_FLAGS)) ? link.wdata[7:0] : 8'h00;
   end

   // sticky flags, set beats clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flags_q <= '0;
      else
         flags_q <= (flags_q & ~clr) | set;
   end

   // interrupt level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_q <= 1'b0;
      else
         irq_q <= |(flags_q & mask_q);
   end

   ////////////////////////////////////////////////////////////////////////
   // automatic scheduler, per-ratio countdowns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pdiv_q <= '0;
         tdiv_q <= '0;
         conv_p_q <= 1'b0;
         conv_t_q <= 1'b0;
      end else begin
         conv_p_q <= 1'b0;
         conv_t_q <= 1'b0;
         if (!auto_on) begin
            pdiv_q <= '0;
            tdiv_q <= '0;
         end else if (auto_tick) begin
            // no pulse at all when neither is due
            conv_p_q <= p_ratio != '0 && pdiv_q == '0;
            conv_t_q <= t_ratio != '0 && tdiv_q == '0;
            pdiv_q <= (pdiv_q == '0) ? p_ratio - 1'b1 : pdiv_q - 1'b1;
            tdiv_q <= (tdiv_q == '0) ? t_ratio - 1'b1 : tdiv_q - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pair storage
   always_ff @(posedge clk) begin
      if (push)
         mem[wp_q] <= {p_result, t_done ? t_result : t_last_q};
   end

   // pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (!fifo_on) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop || (push && cnt_full))
            rp_q <= rp_q + 1'b1;
         if (push && !pop && !cnt_full)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign link.ack     = ack_q;
   assign link.refused = ref_q;
   assign link.rdata   = rdata_q;
   assign link.irq     = irq_q;
   assign conv_p       = conv_p_q;
   assign conv_t       = conv_t_q;
   assign cfg_wr       = cfg_q;
   assign cfg_data     = cfg_data_q;
   assign fifo_count   = cnt_q;
endmodule
`default_nettype wire

// ===== design/ilm_pkg.sv
// constants, command codes and register layout of the event and limit monitor
// Summary of operation
// - config and conversion commands refused in automatic mode
// - pressure-only cycles paired with latest temperature
// - timer cycles with nothing scheduled are skipped
// - interrupt output only for enabled flags
// - all enable bits zero after reset
// - writing one clears that flag only
// - mask and flag command codes, bit zero ignored
// - flag bit order, crc bit one means failure
// - pressure above upper or below lower flags
// - temperature above upper or below lower flags
// - fifo full flag at 32 unread entries
// - threshold flag when unread count reaches threshold
// - flags raised at once, temperature first
// - read gives new temperature, previous pressure
// - done flag set per finished conversion
// - limits compared with upper 16 result bits
// - lower limits zero, upper limits all ones
// - compare only at end of conversion
// - one comparison per actual conversion
// - limit command codes with two-bit select
// - threshold one to thirty-one, zero disables
// - fifo of 32 pairs, first in first out
`default_nettype none
package ilm_pkg;
   localparam int DW = 16;                       // limit and result width
   localparam int FIFO_DEPTH = 32;               // pairs held
   localparam int PW = 5;                        // fifo pointer width
   localparam int RW = 4;                        // rate divider width
   // command codes, bits 7..1
   localparam logic [6:0] CMD_WR_MASK  = 7'h0c;
   localparam logic [6:0] CMD_RD_MASK  = 7'h0d;
   localparam logic [6:0] CMD_WR_FLAGS = 7'h0e;
   localparam logic [6:0] CMD_RD_FLAGS = 7'h0f;
   // bits 7..3 of limit and config commands
   localparam logic [4:0] CMD_WR_LIMIT = 5'h06;
   localparam logic [4:0] CMD_RD_LIMIT = 5'h07;
   localparam logic [4:0] CMD_WR_CFG   = 5'h04;
   localparam logic [3:0] CMD_CONV     = 4'h4;   // bits 7..4
   localparam logic [3:0] CMD_RD_ADC   = 4'h5;   // bits 7..4
   // limit select
   localparam logic [1:0] SEL_T_LOW  = 2'h0;
   localparam logic [1:0] SEL_T_HIGH = 2'h1;
   localparam logic [1:0] SEL_P_LOW  = 2'h2;
   localparam logic [1:0] SEL_P_HIGH = 2'h3;
   // flag bit positions
   localparam int FL_CRC = 7;
   localparam int FL_P_HIGH = 6;
   localparam int FL_P_LOW = 5;
   localparam int FL_T_HIGH = 4;
   localparam int FL_T_LOW = 3;
   localparam int FL_FULL = 2;
   localparam int FL_THR = 1;
   localparam int FL_DONE = 0;
   // reset values
   localparam logic [DW-1:0] LOW_RST  = 16'h0000;
   localparam logic [DW-1:0] HIGH_RST = 16'hffff;
   localparam logic [7:0]    MASK_RST = 8'h00;
   // host register offsets on the avalon side
   localparam logic [3:0] HR_WDATA  = 4'h0;
   localparam logic [3:0] HR_CMD    = 4'h4;
   localparam logic [3:0] HR_RDATA  = 4'h8;
   localparam logic [3:0] HR_STATUS = 4'hc;
   typedef enum logic [1:0] {ILM_IDLE = 2'b00, ILM_SEND = 2'b01, ILM_WAIT = 2'b11} ilm_hstate_t;
endpackage
`default_nettype wire

// ===== test/ilm_props.sv
// link checker for the event and limit monitor
`default_nettype none
module ilm_props
   import ilm_pkg::*;
(
   input wire logic        clk,      // 20 MHz clock
   input wire logic        rst_n,    // async reset, active low
   input wire logic        req,      // host request
   input wire logic [7:0]  cmd,      // command byte
   input wire logic [15:0] wdata,    // write data
   input wire logic        ack,      // answer pulse
   input wire logic        refused,  // refusal with ack
   input wire logic [31:0] rdata,    // read data
   input wire logic        irq       // interrupt level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0]  mask_q;
   logic [15:0] lim_q [4];
   ////////////////////////////////////////////////////////////
   // shadow of mask and limits from answered writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MASK_RST;
         lim_q  <= '{LOW_RST, HIGH_RST, LOW_RST, HIGH_RST};
      end else if (ack && cmd[7:1] == CMD_WR_MASK) begin
         mask_q <= wdata[7:0];
      end else if (ack && cmd[7:3] == CMD_WR_LIMIT) begin
         lim_q[cmd[2:1]] <= wdata;
      end
   end
   ////////////////////////////////////////////////////////////
   // request and answer steps of one link transfer
   sequence s_take;
      req && !ack;
   endsequence
   sequence s_answer;
      ack ##1 !ack;
   endsequence
   a_take_answered: assert property (s_take |=> s_answer)
      else $error("link request not answered with a single ack");
   a_ack_needs_req: assert property (ack |-> req)
      else $error("ack without a pending request");
   a_req_held: assert property (s_take |=> req && $stable(cmd) && $stable(wdata))
      else $error("request dropped or changed before ack");
   a_refuse_auto_only: assert property (ack && refused |->
      cmd[7:3] == CMD_WR_CFG || cmd[7:4] == CMD_CONV)
      else $error("refusal of a command that is always allowed");
   a_mask_readback: assert property (ack && cmd[7:1] == CMD_RD_MASK |->
      rdata[7:0] == mask_q)
      else $error("mask read differs from last mask write");
   a_limit_readback: assert property (ack && cmd[7:3] == CMD_RD_LIMIT |->
      rdata[15:0] == lim_q[cmd[2:1]])
      else $error("limit read differs from reset or written value");
   a_irq_masked: assert property ((mask_q == 8'h00) [*4] |-> !irq)
      else $error("interrupt raised with every enable bit clear");
   a_rdata_stands: assert property (!ack |-> $stable(rdata))
      else $error("read data changed without an answer");
endmodule
`default_nettype wire

// ===== test/tb_interrupt_limit_monitor.sv
// self-checking bench: host end and monitor end joined by the link
`default_nettype none
module tb_interrupt_limit_monitor
   import ilm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk, rst_n, crc_fail, auto_on, auto_tick, fifo_on, t_go, p_go, fifo_wrap;
   logic          t_done = 1'b0, p_done = 1'b0, p_pipe = 1'b0;
   logic [15:0]   t_result = '0, p_result = '0, tc = '0, pc = '0;
   logic [15:0]   t_val, p_val, tv, pv, pv_prev;
   logic [15:0]   lim [4];
   logic [RW-1:0] p_ratio, t_ratio;
   logic [PW-1:0] fifo_thr;
   logic          conv_p, conv_t, cfg_wr, avs_read, avs_write, avs_waitrequest, crc;
   logic [DW-1:0] cfg_data;
   logic [PW:0]   fifo_count;
   logic [3:0]    avs_address;
   logic [7:0]    ex, mk;
   logic [31:0]   avs_writedata, avs_readdata, st, q;
   int            err_count = 0, check_count = 0, cfg_cnt = 0, cyc = 0, seed = 32'hff04;
   ilm_link_if link_i ();
   ilm_monitor ilm_monitor_i (.clk(clk), .rst_n(rst_n), .link(link_i.dev), .t_done(t_done),
      .t_result(t_result), .p_done(p_done), .p_result(p_result), .crc_fail(crc_fail),
      .auto_on(auto_on), .auto_tick(auto_tick), .p_ratio(p_ratio), .t_ratio(t_ratio),
      .fifo_on(fifo_on), .fifo_wrap(fifo_wrap), .fifo_thr(fifo_thr), .conv_p(conv_p),
      .conv_t(conv_t), .cfg_wr(cfg_wr), .cfg_data(cfg_data), .fifo_count(fifo_count));
   ilm_host ilm_host_i (.clk(clk), .rst_n(rst_n), .link(link_i.host), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   ilm_props ilm_props_i (.clk(clk), .rst_n(rst_n), .req(link_i.req), .cmd(link_i.cmd),
      .wdata(link_i.wdata), .ack(link_i.ack), .refused(link_i.refused), .rdata(link_i.rdata),
      .irq(link_i.irq));
   ////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // converter model: temperature one cycle, pressure two cycles after start
   always @(posedge clk) begin
      t_done <= conv_t || t_go;
      t_result <= conv_t ? 16'h2000 + tc : (t_go ? t_val : t_result);
      tc <= tc + 16'(conv_t);
      p_pipe <= conv_p;
      p_done <= p_pipe || p_go;
      p_result <= p_pipe ? 16'h1000 + pc : (p_go ? p_val : p_result);
      pc <= pc + 16'(p_pipe);
   end
   // config write count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cfg_wr !== 1'b0) cfg_cnt <= cfg_cnt + 1;
      if (cyc == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // one link command, bit zero random; status in st, answer in q
   task automatic lnk(input logic [7:0] c, input logic [15:0] d);
      av(1'b1, HR_WDATA, {16'h0000, d});
      av(1'b1, HR_CMD, {24'h000000, c[7:1], 1'($random(seed))});
      do begin
         av(1'b0, HR_STATUS, 32'h00000000);
         st = q;
      end while (st[0] !== 1'b0);
      av(1'b0, HR_RDATA, 32'h00000000);
   endtask
   function automatic logic [1:0] lim_bits(input logic [15:0] v, lo, hi);
      return {v > hi, v < lo};
   endfunction
   // automatic run with fifo, then refusals, counts, flags and pair readout
   // sk oldest pairs are lost to overwrite in wrap mode
   task automatic auto_run(input logic [3:0] pr, tr, input logic [PW-1:0] th, input logic wp,
                           input int tk, n, sk);
      logic [15:0] p0, t0;
      logic [31:0] e;
      p0 = pc;
      t0 = tc;
      lnk({CMD_WR_FLAGS, 1'b0}, 16'h00ff);
      p_ratio <= pr;
      t_ratio <= tr;
      fifo_thr <= th;
      fifo_wrap <= wp;
      fifo_on <= 1'b1;
      auto_on <= 1'b1;
      repeat (tk) begin
         @(posedge clk);
         auto_tick <= 1'b1;
         @(posedge clk);
         auto_tick <= 1'b0;
         repeat (6) @(posedge clk);
      end
      lnk({CMD_WR_CFG, 3'h0}, 16'h1234);
      chk(st[1], 1'b1);
      lnk({CMD_CONV, 4'hc}, 16'h0000);
      chk(st[1], 1'b1);
      auto_on <= 1'b0;
      chk({26'h0, fifo_count}, 32'(n));
      lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
      chk(q[2:1], {n == 32, th != '0 && n >= th});
      for (int j = 0; j < n; j++) begin
         lnk({CMD_RD_ADC, 4'hc}, 16'h0000);
         e = {16'(16'h1000 + p0 + j + sk), 16'(16'h2000 + t0 + ((j + sk) * pr) / tr)};
         chk(q, e);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_n = 1'b0;
      {crc_fail, auto_on, auto_tick, fifo_on, t_go, p_go, avs_read, avs_write} = 8'h00;
      {p_ratio, t_ratio, fifo_thr, avs_address, fifo_wrap} = '0;
      {avs_writedata, t_val, p_val, pv_prev} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         lnk({CMD_RD_LIMIT, 2'(s), 1'b0}, 16'h0000);
         chk(q[15:0], s[0] ? HIGH_RST : LOW_RST);
      end
      lnk({CMD_RD_MASK, 1'b0}, 16'h0000);
      chk(q[7:0], MASK_RST);
      for (int i = 0; i < 8; i++) begin
         mk = 8'($random(seed));
         for (int s = 0; s < 4; s++) begin
            lim[s] = 16'($random(seed));
            lnk({CMD_WR_LIMIT, 2'(s), 1'b0}, lim[s]);
         end
         lnk({CMD_RD_LIMIT, 2'(i), 1'b0}, 16'h0000);
         chk(q[15:0], lim[i % 4]);
         lnk({CMD_WR_MASK, 1'b0}, {8'h00, mk});
         lnk({CMD_WR_FLAGS, 1'b0}, 16'h00ff);
         crc = 1'($random(seed));
         tv = 16'($random(seed));
         pv = 16'($random(seed));
         @(posedge clk);
         t_val <= tv;
         t_go <= 1'b1;
         crc_fail <= crc;
         @(posedge clk);
         t_go <= 1'b0;
         crc_fail <= 1'b0;
         ex = {crc, 2'b00, lim_bits(tv, lim[0], lim[1]), 3'b001};
         lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
         chk(q[7:0], ex);
         lnk({CMD_RD_ADC, 4'hc}, 16'h0000);
         chk(q, {pv_prev, tv});
         lnk({CMD_WR_FLAGS, 1'b0}, 16'h0001);
         @(posedge clk);
         p_val <= pv;
         p_go <= 1'b1;
         @(posedge clk);
         p_go <= 1'b0;
         ex = ex | {1'b0, lim_bits(pv, lim[2], lim[3]), 5'b00001};
         lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
         chk(q[7:0], ex);
         chk(link_i.irq, |(ex & mk));
         lnk({CMD_WR_FLAGS, 1'b0}, 16'h0005);
         lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
         chk(q[7:0], ex & 8'hfa);
         pv_prev = pv;
      end
      lnk({CMD_WR_FLAGS, 1'b0}, 16'h00ff);
      lnk({CMD_WR_LIMIT, SEL_T_HIGH, 1'b0}, 16'h0000);
      lnk({CMD_WR_LIMIT, SEL_P_LOW, 1'b0}, 16'hffff);
      lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
      chk(q[7:0], 8'h00);
      chk(link_i.irq, 1'b0);
      // done event lands on the edge that applies a done clear
      tv = 16'h0001;
      fork
         lnk({CMD_WR_FLAGS, 1'b0}, 16'h0001);
         begin
            repeat (5) @(posedge clk);
            t_val <= tv;
            t_go <= 1'b1;
            @(posedge clk);
            t_go <= 1'b0;
         end
      join
      lnk({CMD_RD_FLAGS, 1'b0}, 16'h0000);
      chk(q[7:0], {3'b000, lim_bits(tv, lim[0], 16'h0000), 3'b001});
      auto_run(4'h1, 4'h4, 5'h00, 1'b0, 32, 32, 0);
      auto_run(4'h2, 4'h4, 5'h04, 1'b0, 8, 4, 0);
      auto_run(4'h1, 4'h1, 5'h00, 1'b1, 33, 32, 1);
      chk({16'h0000, cfg_data}, 32'h00000000);
      tv = 16'($random(seed));
      lnk({CMD_WR_CFG, 3'h0}, tv);
      chk(st[1], 1'b0);
      chk({16'h0000, cfg_data}, {16'h0000, tv});
      chk(32'(cfg_cnt), 32'h00000001);
      report_and_stop();
   end
endmodule
`default_nettype wire
